// ### common/ulpp_pkg.sv
package ulpp_pkg;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned RESET_MIN_NS    = 1000;
  localparam int unsigned RESET_MIN_CYC   = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RST_CNT_W       = 8;
  localparam int unsigned DIV_W           = 4;
  localparam logic [DIV_W-1:0] DIV_HALF_DEF = 4'h1;
  localparam logic [DATA_W-1:0] CMD_IDLE    = 8'h00;

  typedef logic [DATA_W-1:0] ulpp_byte_type;

  typedef struct packed {
    logic          valid;
    ulpp_byte_type data;
  } ulpp_beat_type;

  typedef struct packed {
    ulpp_byte_type data_out;
    logic          data_oe;
    logic          dir;
    logic          nxt;
    logic          clk_out;
    logic          pins_oe;
  } ulpp_pins_type;

  typedef enum logic [1:0] {ULPP_IDLE, ULPP_TURN_OUT, ULPP_SEND, ULPP_RECV} ulpp_state_type;
endpackage

// ### rtl/ulpp_reset_sync.sv
module ulpp_reset_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      active,
  output logic      long_done
);
  import ulpp_pkg::*;

  logic [2:0]           sync;
  logic [RST_CNT_W-1:0] low_cnt;

  // three flops, release counted when second and third are both high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
    end else if (sync[1] && sync[2]) begin
      active <= 1'b1;
    end
  end

  // counts low time; reset must last RESET_MIN_CYC before release
  always_ff @(posedge clk) begin
    if (rst_n) begin
      low_cnt <= '0;
    end else if (low_cnt != RST_CNT_W'(RESET_MIN_CYC)) begin
      low_cnt <= low_cnt + RST_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    long_done <= (low_cnt == RST_CNT_W'(RESET_MIN_CYC));
  end
endmodule

// ### rtl/ulpp_port.sv
module ulpp_port #(
  parameter logic [ulpp_pkg::DIV_W-1:0] DIV_HALF = ulpp_pkg::DIV_HALF_DEF
)(
  input  wire logic                    CORE_CLK,
  input  wire logic                    RSTN,
  input  wire logic                    CLOCK_IN_MODE,
  input  wire ulpp_pkg::ulpp_beat_type TX_BEAT,
  output logic                         TX_READY,
  output ulpp_pkg::ulpp_beat_type      RX_BEAT,
  output logic                         RX_LAST,
  input  wire ulpp_pkg::ulpp_byte_type DATA_IN,
  input  wire logic                    STOP_IN,
  output ulpp_pkg::ulpp_pins_type      PINS,
  output logic                         AUDIO_SWITCH_ON,
  output logic                         DEFAULTS_LOADED
);
  import ulpp_pkg::*;

  logic           active;
  logic           long_done;
  ulpp_state_type state;
  logic [DIV_W-1:0] div_cnt;

  ulpp_reset_sync u_rst (
    .clk       (CORE_CLK),
    .rst_n     (RSTN),
    .active    (active),
    .long_done (long_done)
  );

  // interface clock divided from reference in clock-out mode
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_cnt      <= '0;
      PINS.clk_out <= 1'b0;
    end else if (CLOCK_IN_MODE) begin
      PINS.clk_out <= 1'b0;
    end else if (div_cnt == DIV_HALF) begin
      div_cnt      <= '0;
      PINS.clk_out <= ~PINS.clk_out;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AUDIO_SWITCH_ON <= 1'b1;
    end else begin
      AUDIO_SWITCH_ON <= !active;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DEFAULTS_LOADED <= 1'b0;
    end else if (long_done) begin
      DEFAULTS_LOADED <= 1'b1;
    end
  end

  // bus ownership and transfer state
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= ULPP_IDLE;
    end else if (!active) begin
      state <= ULPP_IDLE;
    end else begin
      unique case (state)
        ULPP_IDLE: begin
          if (TX_BEAT.valid) begin
            state <= ULPP_TURN_OUT;
          end else if (DATA_IN != CMD_IDLE) begin
            state <= ULPP_RECV;
          end
        end
        ULPP_TURN_OUT: state <= ULPP_SEND;
        ULPP_SEND: begin
          if (!TX_BEAT.valid) begin
            state <= ULPP_IDLE;
          end
        end
        ULPP_RECV: begin
          if (STOP_IN) begin
            state <= ULPP_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PINS.dir <= 1'b0;
    end else begin
      PINS.dir <= active && TX_BEAT.valid && (state != ULPP_RECV);
    end
  end

  // whole pin set floats until reset release has been synchronised
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PINS.pins_oe <= 1'b0;
    end else begin
      PINS.pins_oe <= active;
    end
  end

  // output enable only after turnaround cycle
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PINS.data_oe  <= 1'b0;
      PINS.data_out <= '0;
    end else begin
      PINS.data_oe  <= active && (state == ULPP_SEND || state == ULPP_TURN_OUT) && TX_BEAT.valid;
      PINS.data_out <= TX_BEAT.data;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TX_READY <= 1'b0;
    end else begin
      TX_READY <= active && (state == ULPP_TURN_OUT || state == ULPP_SEND) && TX_BEAT.valid;
    end
  end

  // accept each link byte; next byte arrives cycle after
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PINS.nxt <= 1'b0;
    end else begin
      PINS.nxt <= active && !STOP_IN && !PINS.dir &&
                  (state == ULPP_RECV || (state == ULPP_IDLE && DATA_IN != CMD_IDLE));
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RX_BEAT <= '0;
      RX_LAST <= 1'b0;
    end else begin
      RX_BEAT.valid <= PINS.nxt && !STOP_IN;
      RX_BEAT.data  <= DATA_IN;
      RX_LAST       <= (state == ULPP_RECV) && STOP_IN;
    end
  end

  property p_tristate_reset;
    @(posedge CORE_CLK) !active |-> !PINS.data_oe && !PINS.nxt && !PINS.pins_oe;
  endproperty
  a_tristate_reset: assert property (p_tristate_reset) else $error("outputs driven while suspended");

  property p_dir_needs_data;
    @(posedge CORE_CLK) disable iff (!RSTN) PINS.dir |-> $past(TX_BEAT.valid);
  endproperty
  a_dir_needs_data: assert property (p_dir_needs_data) else $error("direction raised with no data");

  property p_no_drive_dir_low;
    @(posedge CORE_CLK) disable iff (!RSTN) PINS.data_oe |-> PINS.dir;
  endproperty
  a_no_drive_dir_low: assert property (p_no_drive_dir_low) else $error("bus driven while receiving");

  property p_nxt_not_on_stop;
    @(posedge CORE_CLK) disable iff (!RSTN) STOP_IN |=> !PINS.nxt;
  endproperty
  a_nxt_not_on_stop: assert property (p_nxt_not_on_stop) else $error("next after stop");

  property p_stop_last;
    @(posedge CORE_CLK) disable iff (!RSTN) (state == ULPP_RECV && STOP_IN) |=> RX_LAST && (state == ULPP_IDLE);
  endproperty
  a_stop_last: assert property (p_stop_last) else $error("stop did not end stream");

  property p_audio_reset;
    @(posedge CORE_CLK) !active |=> AUDIO_SWITCH_ON;
  endproperty
  a_audio_reset: assert property (p_audio_reset) else $error("audio switch open in reset");

  property p_rx_follows_nxt;
    @(posedge CORE_CLK) disable iff (!RSTN) RX_BEAT.valid |-> $past(PINS.nxt);
  endproperty
  a_rx_follows_nxt: assert property (p_rx_follows_nxt) else $error("byte taken without next");

  property p_idle_leaves_dir;
    @(posedge CORE_CLK) disable iff (!RSTN) !active |=> !PINS.dir;
  endproperty
  a_idle_leaves_dir: assert property (p_idle_leaves_dir) else $error("direction high before release");

  c_send: cover property (@(posedge CORE_CLK) disable iff (!RSTN) PINS.dir ##1 PINS.data_oe);
  c_recv: cover property (@(posedge CORE_CLK) disable iff (!RSTN) PINS.nxt ##1 PINS.nxt);
  c_stop: cover property (@(posedge CORE_CLK) disable iff (!RSTN) RX_LAST);
endmodule

// ### testbench/ulpp_link_model.sv
module ulpp_link_model
  import ulpp_pkg::*;
(
  input  wire logic          clk,
  input  wire ulpp_pins_type pins,
  output ulpp_byte_type      data,
  output logic               stop
);
  timeunit 1ns;
  timeprecision 1ps;
  ulpp_byte_type q[$];
  logic          took;
  initial begin
    data = CMD_IDLE;
    stop = 1'b0;
  end
  always @(posedge clk) begin
    took = pins.nxt && !stop;
    #1;
    stop = 1'b0;
    if (q.size() != 0 && !pins.dir) begin
      if (took) void'(q.pop_front());
      if (q.size() != 0) data = q[0];
      else begin
        // byte before this pulse was the last
        stop = 1'b1;
        data = CMD_IDLE;
      end
    end
  end
endmodule

// ### testbench/ulpi_phy_port_pins_bench.sv
module ulpi_phy_port_pins_bench;
  import ulpp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [DIV_W-1:0] HALF = 4'h1;
  logic          CORE_CLK, RSTN, CLOCK_IN_MODE, TX_READY, RX_LAST, STOP_IN, AUDIO_SWITCH_ON, DEFAULTS_LOADED;
  ulpp_beat_type TX_BEAT, RX_BEAT;
  ulpp_byte_type DATA_IN, last_out;
  ulpp_pins_type PINS;
  logic          prev_clk;
  ulpp_byte_type exp_q[$];
  int            n_errors, n_tests, n_last, n_pkts, rises, i;
  logic [31:0]   seed;
  ulpp_link_model link (.clk(CORE_CLK), .pins(PINS), .data(DATA_IN), .stop(STOP_IN));
  ulpp_port #(.DIV_HALF(HALF)) dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CLOCK_IN_MODE(CLOCK_IN_MODE),
    .TX_BEAT(TX_BEAT), .TX_READY(TX_READY), .RX_BEAT(RX_BEAT), .RX_LAST(RX_LAST), .DATA_IN(DATA_IN),
    .STOP_IN(STOP_IN), .PINS(PINS), .AUDIO_SWITCH_ON(AUDIO_SWITCH_ON), .DEFAULTS_LOADED(DEFAULTS_LOADED));
  always #4 CORE_CLK = ~CORE_CLK;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic rx_pkt(input int len);
    int w;
    for (int k = 0; k < len; k++) begin
      seed = lfsr(seed);
      exp_q.push_back(k == 0 ? (seed[7:0] | 8'h01) : seed[7:0]);
      link.q.push_back(exp_q[$]);
    end
    n_pkts++;
    for (w = 0; w < 100 && (link.q.size() != 0 || STOP_IN); w++) cyc(1);
    if (w == 100) chk(0, 1);
    cyc(3);
  endtask
  task automatic tx_byte(input ulpp_byte_type b);
    int w;
    TX_BEAT = {1'b1, b};
    cyc(1);
    chk(PINS.dir, 1);
    w = 0;
    do @(posedge CORE_CLK); while (TX_READY !== 1'b1 && ++w < 20);
    chk(w < 20, 1);
    #1 TX_BEAT = '0;
    cyc(4);
    chk(last_out, b);
    chk(PINS.dir, 0);
  endtask
  always @(posedge CORE_CLK) begin
    if (PINS.data_oe === 1'b1) last_out <= PINS.data_out;
    if (RSTN && RX_BEAT.valid === 1'b1) chk(RX_BEAT.data, exp_q.pop_front());
    if (RSTN && RX_LAST === 1'b1) begin
      n_last++;
      chk(exp_q.size(), 0);
    end
  end
  initial begin
    #100us;
    n_errors++;
    print_verdict();
  end
  initial begin
    CORE_CLK = 0; RSTN = 0; CLOCK_IN_MODE = 0; TX_BEAT = '0; seed = 32'h5865;
    n_errors = 0; n_tests = 0; n_last = 0; n_pkts = 0; last_out = '0;
    cyc(12);
    chk(PINS, 0);
    chk(AUDIO_SWITCH_ON, 1);
    RSTN = 1;
    cyc(5);
    chk(DEFAULTS_LOADED, 0);
    chk(AUDIO_SWITCH_ON, 0);
    chk(PINS.pins_oe, 1);
    rises = 0;
    prev_clk = PINS.clk_out;
    for (i = 0; i < 64; i++) begin
      cyc(1);
      if (prev_clk === 1'b0 && PINS.clk_out === 1'b1) rises++;
      prev_clk = PINS.clk_out;
    end
    chk(rises, 64 / (2 * (HALF + 1)));
    CLOCK_IN_MODE = 1;
    cyc(6);
    rises = 0;
    for (i = 0; i < 16; i++) begin
      cyc(1);
      if (PINS.clk_out !== 1'b0) rises++;
    end
    chk(rises, 0);
    CLOCK_IN_MODE = 0;
    for (i = 0; i < 6; i++) begin
      rx_pkt(1 + i % 4);
      seed = lfsr(seed);
      tx_byte(seed[7:0]);
    end
    cyc(1);
    RSTN = 0;
    #1 chk(PINS, 0);
    cyc(130);
    chk(AUDIO_SWITCH_ON, 1);
    RSTN = 1;
    cyc(4);
    chk(DEFAULTS_LOADED, 1);
    rx_pkt(3);
    chk(n_last, n_pkts);
    chk(exp_q.size(), 0);
    print_verdict();
  end
endmodule
